//--- include/tcc_defs.svh
// What this block does
// - Timer A clock select: codes 0-5 taps 0-5, code 6 tap 11, code 7 event pin.
// - With the event pin selected, timer A counts pin rising edges as an event counter.
// - Timer B selects taps 0-3 and 7-10; timer C selects taps 5-12; no external clock.
// - Timers A and B clear on match and raise their interrupt two clocks after the match.
// - Continue bit at 0 pauses counting, at 1 resumes, keeping the count.
// - Run bit at 0 stops; a 0-to-1 change clears the counter and starts it.
// - Timers A and B count only while run and continue bits are both 1.
// - Single mode counts to the match, interrupts, toggles the output, then stops.
// - Modulo-N mode interrupts and toggles at every match and keeps counting again.
// - Modulo-N half-rate bit at 1 gives an interrupt on every second time-out only.
// - Output pins of timers A and B toggle on every time-out in both modes.
// - Initial-level bit sets the output and selects the low or high match value.
// - Capture bit makes timer A capture and restart on external interrupt two rising edges.
// - Running counts of timers A and B can be read while counting.
// - Active-low reset stops every timer.
// - Timer C clears on match with its match value and raises its interrupt.
// - Timer C period comes from its tap and match value; run rising edge restarts it.
// - Timer C count can be read at any time.
// - Timer C has a pause/continue bit and a run/stop bit like the others.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_IDX_MODE_A 8'hD0
`define TCC_IDX_MODE_B 8'hD1
`define TCC_IDX_MODE_C 8'hD2
`define TCC_IDX_CFG 8'hD3
`define TCC_IDX_MATCH_A_LO 8'hD4
`define TCC_IDX_MATCH_A_HI 8'hD5
`define TCC_IDX_MATCH_B 8'hD6
`define TCC_IDX_MATCH_C 8'hD7
`define TCC_IDX_COUNT_A 8'hD8
`define TCC_IDX_COUNT_B 8'hD9
`define TCC_IDX_COUNT_C 8'hDA
`define TCC_IDX_CAPTURE_A 8'hDB
`define TCC_IDX_OUT_STAT 8'hDC
`define TCC_IDX_MSB 9
`define TCC_IDX_LSB 2
`define TCC_MODE_RST 8'h00
`define TCC_MASK_B 8'hF7
`define TCC_MASK_C 8'h1F
`define TCC_A_CAP 7
`define TCC_A_RUN 6
`define TCC_A_CONT 5
`define TCC_A_SINGLE 4
`define TCC_A_HALF 3
`define TCC_B_RUN 7
`define TCC_B_CONT 6
`define TCC_B_SINGLE 5
`define TCC_B_HALF 4
`define TCC_C_RUN 4
`define TCC_C_CONT 3
`define TCC_SEL_MSB 2
`define TCC_CFG_INIT_A 0
`define TCC_CFG_INIT_B 1
`define TCC_SEL_TAPA 3'h6
`define TCC_SEL_EVENT 3'h7
`define TCC_TAP_A6 4'hB
`define TCC_B_OFS 4'h3
`define TCC_C_OFS 4'h5
`define TCC_PS_W 13
`define TCC_RESP_OK 2'h0
`define TCC_RESP_ERR 2'h2
`endif

//--- include/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
    typedef logic [7:0] tcc_mode_t;
    typedef logic [3:0] tcc_tap_t;
    typedef logic [15:0] tcc_word_t;
endpackage : tcc_pkg
`default_nettype wire

//--- verilog/tcc_timer_top.sv
`include "tcc_defs.svh"
`default_nettype none
module tcc_chan
#(
    parameter int W = 16,
    parameter bit HAS_OUT = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic runBit,
    input wire logic contBit,
    input wire logic singleMode,
    input wire logic halfRate,
    input wire logic outInit,
    input wire logic capMode,
    input wire logic capEdge,
    input wire logic [W-1:0] matchLo,
    input wire logic [W-1:0] matchHi,
    output logic [W-1:0] count,
    output logic [W-1:0] capVal,
    output logic outLevel,
    output logic irq
);
    logic runPrev_reg;
    logic done_reg;
    logic half_reg;
    logic hit_reg;
    logic irq_reg;
    logic out_reg;
    logic [W-1:0] count_reg;
    logic [W-1:0] cap_reg;

    // A run edge restarts; counting needs run, continue and no finished single shot.
    wire start = runBit & ~runPrev_reg;
    wire active = runBit & contBit & ~done_reg;
    wire [W-1:0] cmpVal = (HAS_OUT && out_reg) ? matchHi : matchLo;
    wire match = active & tick & ~capMode & ~start & (count_reg == cmpVal);
    wire capHit = active & capMode & capEdge & ~start;
    wire irqNext = hit_reg & (singleMode | ~halfRate | half_reg);

    // Interrupt is registered one cycle behind hit_reg, two cycles behind the match, so the parity bit is settled.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            runPrev_reg <= 1'b0;
            hit_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            runPrev_reg <= runBit;
            hit_reg <= match;
            irq_reg <= irqNext;
        end
    end

    // Counter, output level, single-shot stop and half-rate parity.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            count_reg <= '0;
            cap_reg <= '0;
            done_reg <= 1'b0;
            half_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else if (start)
        begin
            count_reg <= '0;
            done_reg <= 1'b0;
            half_reg <= 1'b0;
            out_reg <= HAS_OUT & outInit;
        end
        else
        begin
            if (capHit)
            begin
                cap_reg <= count_reg;
                count_reg <= '0;
            end
            else if (match)
            begin
                count_reg <= '0;
                out_reg <= out_reg ^ HAS_OUT;
                done_reg <= singleMode;
            end
            else if (active & tick)
            begin
                count_reg <= count_reg + 1'b1;
            end
            if (hit_reg)
            begin
                half_reg <= ~half_reg;
            end
        end
    end

    assign count = count_reg;
    assign capVal = cap_reg;
    assign outLevel = out_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_timeout;
        match && (singleMode || !halfRate);
    endsequence
    sequence s_irq_pulse;
        irq ##1 !irq;
    endsequence

    property p_start_clear;
        start |=> count_reg == '0;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("Restart did not clear");

    property p_pause_hold;
        runBit && !contBit && !start |=> count_reg == $past(count_reg);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("Count moved in pause");

    property p_stop_hold;
        !runBit |=> count_reg == $past(count_reg);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("Count moved when stopped");

    property p_match_clear;
        match |=> count_reg == '0 && hit_reg;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("Match did not clear");

    property p_irq_timeout;
        s_timeout |-> ##2 s_irq_pulse;
    endproperty
    a_irq_timeout: assert property (p_irq_timeout) else $error("Time-out irq missing");

    property p_half_skip;
        match && !singleMode && halfRate && !half_reg |-> ##2 !irq;
    endproperty
    a_half_skip: assert property (p_half_skip) else $error("Half-rate irq too early");

    property p_toggle;
        match && HAS_OUT |=> out_reg != $past(out_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Output did not toggle");

    property p_single_stop;
        match && singleMode |=> done_reg && !active ##1 count_reg == '0;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("Single shot ran on");
endmodule : tcc_chan

module tcc_timer_top
    import tcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic eventCountPin,
    input wire logic externalIrqTwo,
    output logic timerAIrq,
    output logic timerBIrq,
    output logic timerCIrq,
    output logic timerAOutPin,
    output logic timerBOutPin
);
    tcc_mode_t modeA_reg;
    tcc_mode_t modeB_reg;
    tcc_mode_t modeC_reg;
    logic [1:0] cfg_reg;
    tcc_word_t matchALo_reg;
    tcc_word_t matchAHi_reg;
    tcc_word_t matchB_reg;
    logic [7:0] matchC_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] bresp_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [`TCC_PS_W-1:0] ps_reg;
    logic [2:0] tapPrev_reg;
    logic [1:0] pinS1_reg;
    logic [1:0] pinS2_reg;
    logic [1:0] pinS3_reg;
    logic [1:0] pinFilt_reg;
    tcc_word_t countA;
    tcc_word_t capA;
    logic [7:0] countB;
    logic [7:0] countC;
    logic outA;
    logic outB;

    // Write decode: the write commits once both address and data are held.
    wire wrFire = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire [7:0] wIdx = awAddr_reg[`TCC_IDX_MSB:`TCC_IDX_LSB];
    wire wHit = (wIdx >= `TCC_IDX_MODE_A) && (wIdx <= `TCC_IDX_OUT_STAT);
    wire wrLo = wrFire & wstrb_reg[0];
    wire wrHi = wrFire & wstrb_reg[1];
    wire [7:0] rIdx = araddr[`TCC_IDX_MSB:`TCC_IDX_LSB];
    wire rHit = (rIdx >= `TCC_IDX_MODE_A) && (rIdx <= `TCC_IDX_OUT_STAT);

    // Read selection; counts are live so software sees them while running.
    wire [31:0] rdMux =
        (rIdx == `TCC_IDX_MODE_A) ? {24'h000000, modeA_reg} :
        (rIdx == `TCC_IDX_MODE_B) ? {24'h000000, modeB_reg} :
        (rIdx == `TCC_IDX_MODE_C) ? {24'h000000, modeC_reg} :
        (rIdx == `TCC_IDX_CFG) ? {30'h00000000, cfg_reg} :
        (rIdx == `TCC_IDX_MATCH_A_LO) ? {16'h0000, matchALo_reg} :
        (rIdx == `TCC_IDX_MATCH_A_HI) ? {16'h0000, matchAHi_reg} :
        (rIdx == `TCC_IDX_MATCH_B) ? {16'h0000, matchB_reg} :
        (rIdx == `TCC_IDX_MATCH_C) ? {24'h000000, matchC_reg} :
        (rIdx == `TCC_IDX_COUNT_A) ? {16'h0000, countA} :
        (rIdx == `TCC_IDX_COUNT_B) ? {24'h000000, countB} :
        (rIdx == `TCC_IDX_COUNT_C) ? {24'h000000, countC} :
        (rIdx == `TCC_IDX_CAPTURE_A) ? {16'h0000, capA} :
        (rIdx == `TCC_IDX_OUT_STAT) ? {30'h00000000, outB, outA} :
        32'h00000000;

    // Write channel; address and data may arrive in either order.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TCC_RESP_OK;
            awAddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (awvalid && awready_reg)
            begin
                awAddr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg)
            begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
                wready_reg <= 1'b0;
            end
            if (wrFire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wHit ? `TCC_RESP_OK : `TCC_RESP_ERR;
            end
            if (bvalid_reg && bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Read channel answers straight after the address handshake.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `TCC_RESP_OK;
            rdata_reg <= 32'h00000000;
        end
        else if (arvalid && arready_reg)
        begin
            rdata_reg <= rdMux;
            rresp_reg <= rHit ? `TCC_RESP_OK : `TCC_RESP_ERR;
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Register writes; match A and B take both low bytes, the rest only the low byte, reserved mode bits stay zero.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            modeA_reg <= `TCC_MODE_RST;
            modeB_reg <= `TCC_MODE_RST;
            modeC_reg <= `TCC_MODE_RST;
            cfg_reg <= 2'h0;
            matchALo_reg <= 16'h0000;
            matchAHi_reg <= 16'h0000;
            matchB_reg <= 16'h0000;
            matchC_reg <= 8'h00;
        end
        else
        begin
            if (wrLo && wIdx == `TCC_IDX_MODE_A)
                modeA_reg <= wdata_reg[7:0];
            if (wrLo && wIdx == `TCC_IDX_MODE_B)
                modeB_reg <= wdata_reg[7:0] & `TCC_MASK_B;
            if (wrLo && wIdx == `TCC_IDX_MODE_C)
                modeC_reg <= wdata_reg[7:0] & `TCC_MASK_C;
            if (wrLo && wIdx == `TCC_IDX_CFG)
                cfg_reg <= wdata_reg[1:0];
            if (wrLo && wIdx == `TCC_IDX_MATCH_A_LO)
                matchALo_reg[7:0] <= wdata_reg[7:0];
            if (wrHi && wIdx == `TCC_IDX_MATCH_A_LO)
                matchALo_reg[15:8] <= wdata_reg[15:8];
            if (wrLo && wIdx == `TCC_IDX_MATCH_A_HI)
                matchAHi_reg[7:0] <= wdata_reg[7:0];
            if (wrHi && wIdx == `TCC_IDX_MATCH_A_HI)
                matchAHi_reg[15:8] <= wdata_reg[15:8];
            if (wrLo && wIdx == `TCC_IDX_MATCH_B)
                matchB_reg[7:0] <= wdata_reg[7:0];
            if (wrHi && wIdx == `TCC_IDX_MATCH_B)
                matchB_reg[15:8] <= wdata_reg[15:8];
            if (wrLo && wIdx == `TCC_IDX_MATCH_C)
                matchC_reg <= wdata_reg[7:0];
        end
    end

    // Tap selection per timer; timers B and C never see the event pin.
    wire [2:0] selA = modeA_reg[`TCC_SEL_MSB:0];
    wire [2:0] selB = modeB_reg[`TCC_SEL_MSB:0];
    wire [2:0] selC = modeC_reg[`TCC_SEL_MSB:0];
    wire evSel = (selA == `TCC_SEL_EVENT);
    wire [3:0] tapIdxA = (selA == `TCC_SEL_TAPA) ? `TCC_TAP_A6 : {1'b0, selA};
    wire [3:0] tapIdxB = selB[2] ? {1'b0, selB} + `TCC_B_OFS : {1'b0, selB};
    wire [3:0] tapIdxC = {1'b0, selC} + `TCC_C_OFS;
    wire [2:0] tapNow = {ps_reg[tapIdxC], ps_reg[tapIdxB], ps_reg[tapIdxA]};
    wire [2:0] tapRise = tapNow & ~tapPrev_reg;

    // Pin filter: a level is taken once the second and third stages agree.
    wire [1:0] pinAgree = ~(pinS2_reg ^ pinS3_reg);
    wire [1:0] pinFiltNext = (pinS3_reg & pinAgree) | (pinFilt_reg & ~pinAgree);
    wire [1:0] pinRise = pinFiltNext & ~pinFilt_reg;
    wire tickA = evSel ? pinRise[0] : tapRise[0];

    // Prescaler is free running; taps are its bits, so edges need no crossing.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ps_reg <= '0;
            tapPrev_reg <= 3'h0;
            pinS1_reg <= 2'h0;
            pinS2_reg <= 2'h0;
            pinS3_reg <= 2'h0;
            pinFilt_reg <= 2'h0;
        end
        else
        begin
            ps_reg <= ps_reg + 1'b1;
            tapPrev_reg <= tapNow;
            pinS1_reg <= {externalIrqTwo, eventCountPin};
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
            pinFilt_reg <= pinFiltNext;
        end
    end

    // Timer A: 16-bit interval, event or capture counter with an output pin.
    tcc_chan #(.W(16), .HAS_OUT(1'b1)) chanA (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tickA),
        .runBit(modeA_reg[`TCC_A_RUN]),
        .contBit(modeA_reg[`TCC_A_CONT]),
        .singleMode(modeA_reg[`TCC_A_SINGLE]),
        .halfRate(modeA_reg[`TCC_A_HALF]),
        .outInit(cfg_reg[`TCC_CFG_INIT_A]),
        .capMode(modeA_reg[`TCC_A_CAP]),
        .capEdge(pinRise[1]),
        .matchLo(matchALo_reg),
        .matchHi(matchAHi_reg),
        .count(countA),
        .capVal(capA),
        .outLevel(outA),
        .irq(timerAIrq)
    );

    // Timer B: 8-bit interval timer with an output pin.
    tcc_chan #(.W(8), .HAS_OUT(1'b1)) chanB (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tapRise[1]),
        .runBit(modeB_reg[`TCC_B_RUN]),
        .contBit(modeB_reg[`TCC_B_CONT]),
        .singleMode(modeB_reg[`TCC_B_SINGLE]),
        .halfRate(modeB_reg[`TCC_B_HALF]),
        .outInit(cfg_reg[`TCC_CFG_INIT_B]),
        .capMode(1'b0),
        .capEdge(1'b0),
        .matchLo(matchB_reg[7:0]),
        .matchHi(matchB_reg[15:8]),
        .count(countB),
        .capVal(),
        .outLevel(outB),
        .irq(timerBIrq)
    );

    // Timer C: plain modulo interval timer, no output and no single mode.
    tcc_chan #(.W(8), .HAS_OUT(1'b0)) chanC (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tapRise[2]),
        .runBit(modeC_reg[`TCC_C_RUN]),
        .contBit(modeC_reg[`TCC_C_CONT]),
        .singleMode(1'b0),
        .halfRate(1'b0),
        .outInit(1'b0),
        .capMode(1'b0),
        .capEdge(1'b0),
        .matchLo(matchC_reg),
        .matchHi(matchC_reg),
        .count(countC),
        .capVal(),
        .outLevel(),
        .irq(timerCIrq)
    );

    // Bus and pin outputs, all taken from flip-flops.
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign timerAOutPin = outA;
    assign timerBOutPin = outB;
endmodule : tcc_timer_top
`default_nettype wire

//--- verif/tcc_timer_top_tb.sv
`include "tcc_defs.svh"
`default_nettype none
module tcc_timer_top_tb
    import tcc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic eventCountPin = 1'b0;
    logic externalIrqTwo = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic timerAIrq, timerBIrq, timerCIrq, timerAOutPin, timerBOutPin;
    int errors = 0;
    int checksDone = 0;
    int cyc = 0;
    int iq[3][$];
    int oq[2][$];
    int runPos[3] = '{`TCC_A_RUN, `TCC_B_RUN, `TCC_C_RUN};
    int contPos[3] = '{`TCC_A_CONT, `TCC_B_CONT, `TCC_C_CONT};
    logic [7:0] rdMask[3] = '{8'hFF, `TCC_MASK_B, `TCC_MASK_C};
    logic [2:0] irqPrev = 3'h0;
    logic [1:0] outPrev = 2'h0;
    wire logic [2:0] irqV = {timerCIrq, timerBIrq, timerAIrq};
    wire logic [1:0] outV = {timerBOutPin, timerAOutPin};

    tcc_timer_top u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .eventCountPin(eventCountPin), .externalIrqTwo(externalIrqTwo),
        .timerAIrq(timerAIrq), .timerBIrq(timerBIrq), .timerCIrq(timerCIrq),
        .timerAOutPin(timerAOutPin), .timerBOutPin(timerBOutPin));

    // The 200 MHz system clock.
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Logs each interrupt pulse and output change by cycle, so periods are measured exactly.
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        irqPrev <= irqV;
        outPrev <= outV;
        for (int i = 0; i < 3; i++)
        begin
            if (irqV[i] === 1'b1) iq[i].push_back(cyc);
            if (irqV[i] === 1'b1 && irqPrev[i] === 1'b1) fail("interrupt pulse too wide");
            if (i < 2 && outV[i] !== outPrev[i]) oq[i].push_back(cyc);
        end
    end

    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t ns: %s", $time, m);
    endtask : fail

    task automatic chk(input bit ok, input string m);
        checksDone++;
        if (!ok) fail(m);
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cycles

    // Write and response channels; the extra edge keeps a following request off this edge.
    task automatic axWrite(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            r = bresp;
        end
        while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        @(posedge clk_sys);
        if (n >= 100) fail("write never answered");
    endtask : axWrite

    task automatic axRead(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            d = rdata;
            r = rresp;
        end
        while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        @(posedge clk_sys);
        if (n >= 100) fail("read never answered");
    endtask : axRead

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [1:0] r;
        axWrite(idx, d, r);
        chk(r === `TCC_RESP_OK, "write refused");
    endtask : wr

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er,
        input string m);
        logic [31:0] d;
        logic [1:0] r;
        axRead(idx, d, r);
        chk(d === e && r === er, m);
    endtask : rdChk

    // Reference model: the tap each select code reaches, and a mode word for any timer.
    function automatic int tapOf(input int t, input int s);
        if (t == 0) return (s == 6) ? int'(`TCC_TAP_A6) : s;
        if (t == 1) return (s < 4) ? s : s + int'(`TCC_B_OFS);
        return s + int'(`TCC_C_OFS);
    endfunction : tapOf

    function automatic logic [31:0] modeW(input int t, input bit run, input bit cont, input int s);
        return 32'(s) | (32'(run) << runPos[t]) | (32'(cont) << contPos[t]);
    endfunction : modeW

    task automatic waitIrq(input int t, input int cnt);
        int n;
        for (n = 0; n < 20000 && iq[t].size() < cnt; n++) @(posedge clk_sys);
    endtask : waitIrq

    task automatic testDone;
        $display("comparisons %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : testDone

    // Main sequence; every timer is stopped again before the next test starts.
    initial
    begin
        logic [31:0] d, v;
        logic [1:0] r;
        logic [7:0] mIdx, cIdx;
        int n, k;
        void'($urandom(32'h45EB));
        cycles(6);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        for (k = `TCC_IDX_MODE_A; k <= `TCC_IDX_OUT_STAT; k++)
            rdChk(8'(k), 32'h0, 2'h0, "reset value");
        axWrite(8'hE0, 32'h1, r);
        chk(r === `TCC_RESP_ERR, "unmapped write accepted");
        rdChk(8'hE0, 32'h0, `TCC_RESP_ERR, "unmapped read");
        wr(`TCC_IDX_COUNT_A, 32'h1234);
        rdChk(`TCC_IDX_COUNT_A, 32'h0, `TCC_RESP_OK, "read-only count written");
        for (k = 0; k < 3; k++)
        begin
            d = $urandom() & ~(32'h1 << runPos[k]) & 32'hFF;
            wr(8'(`TCC_IDX_MODE_A + k), d);
            rdChk(8'(`TCC_IDX_MODE_A + k), d & 32'(rdMask[k]), 2'h0, "mode readback");
            wr(8'(`TCC_IDX_MODE_A + k), 32'h0);
        end
        $display("test registers finished");
        // Match value zero makes every tick a time-out, so irq spacing equals the tap period.
        for (k = 0; k < 3; k++)
            for (n = 0; n < 8; n++)
            begin
                if (k == 0 && n == 7) continue;
                wr(8'(`TCC_IDX_MODE_A + k), modeW(k, 1, 1, n));
                iq[k].delete();
                waitIrq(k, 2);
                chk(iq[k][1] - iq[k][0] == (2 << tapOf(k, n)), "tick period");
                wr(8'(`TCC_IDX_MODE_A + k), 32'h0);
            end
        $display("test clock select finished");
        wr(`TCC_IDX_CFG, 32'h3);
        wr(`TCC_IDX_MATCH_A_LO, 32'h3);
        wr(`TCC_IDX_MATCH_A_HI, 32'h6);
        wr(`TCC_IDX_MATCH_B, 32'h0905);
        wr(`TCC_IDX_MODE_A, modeW(0, 1, 1, 0) | (32'h1 << `TCC_A_HALF));
        cycles(2);
        oq[0].delete();
        iq[0].delete();
        chk(timerAOutPin === 1'b1, "timer A initial level");
        cycles(60);
        wr(`TCC_IDX_MODE_A, 32'h0);
        cycles(8);
        chk(oq[0].size() >= 4 && oq[0][1] - oq[0][0] == 8 && oq[0][2] - oq[0][1] == 14,
            "modulo toggle spacing");
        chk(iq[0].size() == oq[0].size() / 2, "half-rate interrupt count");
        $display("test modulo finished");
        // Half-rate is set as well: it only thins interrupts in modulo mode.
        wr(`TCC_IDX_MODE_B, modeW(1, 1, 1, 0) | (32'h1 << `TCC_B_SINGLE)
            | (32'h1 << `TCC_B_HALF));
        cycles(2);
        oq[1].delete();
        iq[1].delete();
        chk(timerBOutPin === 1'b1, "timer B initial level");
        cycles(100);
        chk(oq[1].size() == 1 && iq[1].size() == 1 && timerBOutPin === 1'b0, "single");
        rdChk(`TCC_IDX_COUNT_B, 32'h0, 2'h0, "single mode not stopped");
        wr(`TCC_IDX_MODE_B, 32'h0);
        $display("test single finished");
        // Match values are written while every timer is stopped.
        for (k = `TCC_IDX_MATCH_A_LO; k <= `TCC_IDX_MATCH_C; k++) wr(8'(k), 32'hFFFF);
        for (k = 0; k < 3; k++)
        begin
            mIdx = 8'(`TCC_IDX_MODE_A + k);
            cIdx = 8'(`TCC_IDX_COUNT_A + k);
            wr(mIdx, modeW(k, 1, 1, 0));
            cycles(300);
            axRead(cIdx, d, r);
            cycles(100);
            axRead(cIdx, v, r);
            chk(v > d, "count frozen while running");
            wr(mIdx, modeW(k, 1, 0, 0));
            axRead(cIdx, d, r);
            cycles(100);
            rdChk(cIdx, d, 2'h0, "paused count moved");
            wr(mIdx, modeW(k, 0, 1, 0));
            axRead(cIdx, d, r);
            cycles(100);
            rdChk(cIdx, d, 2'h0, "stopped count moved");
            wr(mIdx, modeW(k, 1, 1, 0));
            axRead(cIdx, d, r);
            chk(d < v, "restart kept count");
            wr(mIdx, 32'h0);
        end
        $display("test pause and restart finished");
        wr(`TCC_IDX_MODE_A, modeW(0, 1, 1, `TCC_SEL_EVENT));
        n = 3 + int'($urandom() % 6);
        for (k = 0; k < n; k++)
        begin
            eventCountPin <= 1'b1;
            cycles(8);
            eventCountPin <= 1'b0;
            cycles(8);
        end
        rdChk(`TCC_IDX_COUNT_A, 32'(n), 2'h0, "event edges miscounted");
        // Capture runs on tap 0; tap 1 is not used with capture.
        wr(`TCC_IDX_MODE_A, modeW(0, 1, 1, 0) | (32'h1 << `TCC_A_CAP));
        n = 40 + int'($urandom() % 60);
        externalIrqTwo <= 1'b1;
        cycles(10);
        externalIrqTwo <= 1'b0;
        cycles(n - 10);
        externalIrqTwo <= 1'b1;
        cycles(10);
        externalIrqTwo <= 1'b0;
        cycles(10);
        axRead(`TCC_IDX_CAPTURE_A, d, r);
        chk(d + 1 >= n / 2 && d <= n / 2 + 1, "captured period");
        wr(`TCC_IDX_MODE_A, 32'h0);
        $display("test event and capture finished");
        wr(`TCC_IDX_MATCH_C, 32'h0);
        wr(`TCC_IDX_MODE_C, modeW(2, 1, 1, 0));
        cycles(200);
        rst_b <= 1'b0;
        cycles(2);
        rst_b <= 1'b1;
        iq[2].delete();
        cycles(300);
        chk(iq[2].size() == 0, "timer ran after reset");
        rdChk(`TCC_IDX_MODE_C, 32'h0, 2'h0, "mode kept through reset");
        $display("test reset finished");
        testDone();
    end

    // Cuts a hang short; the whole sequence needs about 40000 cycles.
    initial
    begin
        cycles(100000);
        fail("watchdog expired");
        testDone();
    end
endmodule : tcc_timer_top_tb
`default_nettype wire
